// >>> hdl/baro_pkg.sv
package baro_pkg;

  // register addresses as seen on the chip; the link carries only bits 6:0
  localparam logic [7:0] ADDR_CAL_FIRST = 8'hAA;
  localparam logic [7:0] ADDR_CAL_LAST  = 8'hBF;
  localparam logic [7:0] ADDR_PART      = 8'hD0;
  localparam logic [7:0] ADDR_SRST      = 8'hE0;
  localparam logic [7:0] ADDR_CMD       = 8'hF4;
  localparam logic [7:0] ADDR_RES_HI    = 8'hF6;
  localparam logic [7:0] ADDR_RES_LO    = 8'hF7;
  localparam logic [7:0] ADDR_RES_XL    = 8'hF8;

  // link framing
  localparam int         LINK_ADDR_W = 7;
  localparam int         RW_BIT      = 7;
  localparam logic [2:0] LAST_BIT    = 3'h7;

  // reset values
  localparam logic [7:0] CMD_RST    = 8'h00;
  localparam logic [7:0] RES_HI_RST = 8'h80;
  localparam logic [7:0] RES_LO_RST = 8'h00;
  localparam logic [7:0] RES_XL_RST = 8'h00;
  localparam logic [7:0] IDLE_BYTE  = 8'h00;

  // measurement command fields
  localparam int         OSS_MSB   = 7;
  localparam int         OSS_LSB   = 6;
  localparam int         SCO_BIT   = 5;
  localparam int         MC_MSB    = 4;
  localparam logic [4:0] MC_TEMP   = 5'h0E;
  localparam logic [4:0] MC_PRES   = 5'h14;
  localparam logic [7:0] SRST_KEY  = 8'hB6;

  // part code: value is arbitrary
  localparam logic [7:0] PART_CODE_DEF = 8'h3C;

  // conversion result layout: 16 bits plus 5 extra bits, extra padded by 3 zeros
  localparam int         ADC_W     = 21;
  localparam int         XL_BITS   = 5;
  localparam logic [2:0] XL_PAD    = 3'h0;

  // calibration store
  localparam int CAL_BYTES  = 22;
  localparam int CAL_ADDR_W = 5;

  // timing, figures in ms, clock in MHz; maximum times round down
  localparam real CLK_MHZ        = 200.0;
  localparam real T_START_MS     = 10.0;
  localparam real T_CONV_TEMP_MS = 4.5;
  localparam real T_CONV_OSS0_MS = 4.5;
  localparam real T_CONV_OSS1_MS = 7.5;
  localparam real T_CONV_OSS2_MS = 13.5;
  localparam real T_CONV_OSS3_MS = 25.5;
  localparam int  CYC_START      = $rtoi(T_START_MS * CLK_MHZ * 1000.0);
  localparam int  CYC_CONV_TEMP  = $rtoi(T_CONV_TEMP_MS * CLK_MHZ * 1000.0);
  localparam int  CYC_CONV_OSS0  = $rtoi(T_CONV_OSS0_MS * CLK_MHZ * 1000.0);
  localparam int  CYC_CONV_OSS1  = $rtoi(T_CONV_OSS1_MS * CLK_MHZ * 1000.0);
  localparam int  CYC_CONV_OSS2  = $rtoi(T_CONV_OSS2_MS * CLK_MHZ * 1000.0);
  localparam int  CYC_CONV_OSS3  = $rtoi(T_CONV_OSS3_MS * CLK_MHZ * 1000.0);
  localparam int  CONV_CNT_W     = 23;
  localparam logic [CONV_CNT_W-1:0] CONV_ONE  = 23'h000001;
  localparam logic [CONV_CNT_W-1:0] CONV_ZERO = 23'h000000;

endpackage : baro_pkg

// >>> hdl/baro_trim_rom.sv
`timescale 1ns/1ps
`default_nettype none

module baro_trim_rom #(
  parameter logic [175:0] CONTENT = 176'h1A2B_3C4D_5E6F_7081_92A3_B4C5_D6E7_F809_1A2B_3C4D_5E6F
) (
  input  wire logic                            mclk_i,
  input  wire logic                            resetn_i,
  input  wire logic [baro_pkg::CAL_ADDR_W-1:0] addr_i,
  output var  logic [7:0]                      rdata_o
);

  // byte 0 is the lowest address, held in the top bits of the vector
  logic [7:0] byte_w;
  assign byte_w = (int'(addr_i) < baro_pkg::CAL_BYTES)
                ? CONTENT[8*(baro_pkg::CAL_BYTES-1-int'(addr_i)) +: 8]
                : baro_pkg::IDLE_BYTE;

  // registered read, one cycle of latency
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= baro_pkg::IDLE_BYTE;
    end else begin
      rdata_o <= byte_w;
    end
  end

endmodule : baro_trim_rom

`default_nettype wire

// >>> hdl/baro_sensor_spi_regmap.sv
// Behaviour
// - four-wire link, clock idles high, mode 3, at most 10 MHz
// - writable registers are volatile; reset restores them, master rewrites command
// - command bits 4:0 select the measurement started by the write
// - busy bit 5 reads one until results are updated, then clears
// - command bits 7:6 pick oversampling one, two, four or eight samples
// - restart register write-only; only 0xB6 restarts like power-on
// - part code register returns a fixed read-only byte
// - results read in any order, single or burst, without change
// - link carries writes, calibration reads and finished results
// - first byte: bit 7 read flag, then low seven address bits
// - reads stream from the address, incrementing after every byte
// - sample on rising, drive on falling; frame spans chip select low
`timescale 1ns/1ps
`default_nettype none

module baro_sensor_spi_regmap #(
  parameter logic [7:0] PART_CODE     = baro_pkg::PART_CODE_DEF,
  parameter int         CONV_TEMP_CYC = baro_pkg::CYC_CONV_TEMP,
  parameter int         CONV_OSS0_CYC = baro_pkg::CYC_CONV_OSS0,
  parameter int         CONV_OSS1_CYC = baro_pkg::CYC_CONV_OSS1,
  parameter int         CONV_OSS2_CYC = baro_pkg::CYC_CONV_OSS2,
  parameter int         CONV_OSS3_CYC = baro_pkg::CYC_CONV_OSS3
) (
  input  wire logic                       mclk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       sck_i,
  input  wire logic                       csn_i,
  input  wire logic                       sdi_i,
  input  wire logic [baro_pkg::ADC_W-1:0] adc_result_i,
  output var  logic                       sdo_o,
  output var  logic                       sdo_oe_o,
  output var  logic                       conv_busy_o
);

  localparam int CW = baro_pkg::CONV_CNT_W;
  localparam int AW = baro_pkg::LINK_ADDR_W;

  // pins cross into mclk through two flops: {sck, csn, sdi}
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic       sck_prev_reg;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_reg    <= 3'h6;
      sync2_reg    <= 3'h6;
      sck_prev_reg <= 1'b1;
    end else begin
      sync1_reg    <= {sck_i, csn_i, sdi_i};
      sync2_reg    <= sync1_reg;
      sck_prev_reg <= sync2_reg[2];
    end
  end

  // edges of the link clock, seen only while selected
  logic sck_s, csn_s, sdi_s, sck_rise, sck_fall;
  assign sck_s    = sync2_reg[2];
  assign csn_s    = sync2_reg[1];
  assign sdi_s    = sync2_reg[0];
  assign sck_rise = !csn_s && sck_s && !sck_prev_reg;
  assign sck_fall = !csn_s && !sck_s && sck_prev_reg;

  // frame state
  logic [2:0]    bit_cnt_reg;
  logic [6:0]    rx_reg;
  logic          ctrl_phase_reg;
  logic          rd_mode_reg;
  logic [AW-1:0] ptr_reg;
  logic [1:0]    load_pipe_reg;
  logic [7:0]    tx_reg;
  logic          sdo_reg;
  logic          sdo_oe_reg;

  // register file
  logic [7:0]    cmd_reg;
  logic [7:0]    res_hi_reg;
  logic [7:0]    res_lo_reg;
  logic [7:0]    res_xl_reg;
  logic [CW-1:0] conv_cnt_reg;

  // byte assembly and decoding of a finished byte
  logic       byte_done, ctrl_done, data_done, wr_stb;
  logic [7:0] rx_byte;
  assign rx_byte   = {rx_reg, sdi_s};
  assign byte_done = sck_rise && (bit_cnt_reg == baro_pkg::LAST_BIT);
  assign ctrl_done = byte_done && ctrl_phase_reg;
  assign data_done = byte_done && !ctrl_phase_reg;
  assign wr_stb    = data_done && !rd_mode_reg;

  // write targets; only seven address bits travel, so compare on those
  logic hit_cmd, hit_srst, cmd_valid, cmd_pres, srst_hit;
  assign hit_cmd   = ptr_reg == baro_pkg::ADDR_CMD[AW-1:0];
  assign hit_srst  = ptr_reg == baro_pkg::ADDR_SRST[AW-1:0];
  assign cmd_pres  = rx_byte[baro_pkg::MC_MSB:0] == baro_pkg::MC_PRES;
  assign cmd_valid = cmd_pres || (rx_byte[baro_pkg::MC_MSB:0] == baro_pkg::MC_TEMP);
  assign srst_hit  = wr_stb && hit_srst && (rx_byte == baro_pkg::SRST_KEY);

  // frame sequencing: control byte, then data; writes alternate control and data
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt_reg    <= 3'h0;
      rx_reg         <= 7'h00;
      ctrl_phase_reg <= 1'b1;
      rd_mode_reg    <= 1'b0;
      ptr_reg        <= 7'h00;
    end else if (csn_s) begin
      bit_cnt_reg    <= 3'h0;
      ctrl_phase_reg <= 1'b1;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg      <= rx_byte[6:0];
      if (ctrl_done) begin
        rd_mode_reg    <= rx_byte[baro_pkg::RW_BIT];
        ptr_reg        <= rx_byte[AW-1:0];
        ctrl_phase_reg <= 1'b0;
      end else if (data_done && rd_mode_reg) begin
        ptr_reg <= ptr_reg + 7'h01;
      end else if (data_done) begin
        ctrl_phase_reg <= 1'b1;
      end
    end
  end

  // calibration bytes live in their own store; unmapped reads give zero
  logic [AW-1:0]                   cal_off;
  logic                            hit_cal;
  logic [7:0]                      cal_rdata;
  assign cal_off = ptr_reg - baro_pkg::ADDR_CAL_FIRST[AW-1:0];
  assign hit_cal = (ptr_reg >= baro_pkg::ADDR_CAL_FIRST[AW-1:0])
                && (ptr_reg <= baro_pkg::ADDR_CAL_LAST[AW-1:0]);

  baro_trim_rom u_trim_rom (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .addr_i   (cal_off[baro_pkg::CAL_ADDR_W-1:0]),
    .rdata_o  (cal_rdata)
  );

  // read data select; the restart register reads as zero, being write-only
  logic [7:0] rd_mux;
  assign rd_mux = hit_cal                                            ? cal_rdata  :
                  (ptr_reg == baro_pkg::ADDR_PART[AW-1:0])           ? PART_CODE  :
                  hit_cmd                                            ? cmd_reg    :
                  (ptr_reg == baro_pkg::ADDR_RES_HI[AW-1:0])         ? res_hi_reg :
                  (ptr_reg == baro_pkg::ADDR_RES_LO[AW-1:0])         ? res_lo_reg :
                  (ptr_reg == baro_pkg::ADDR_RES_XL[AW-1:0])         ? res_xl_reg :
                  baro_pkg::IDLE_BYTE;

  // load waits two cycles so the pointer and the store's registered read settle;
  // the falling edge that needs the byte is at least four cycles away
  logic load_req;
  assign load_req = byte_done && (ctrl_done ? rx_byte[baro_pkg::RW_BIT] : rd_mode_reg);
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      load_pipe_reg <= 2'h0;
      tx_reg        <= baro_pkg::IDLE_BYTE;
    end else begin
      load_pipe_reg <= {load_pipe_reg[0], load_req};
      if (load_pipe_reg[1]) begin
        tx_reg <= rd_mux;
      end else if (sck_fall) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // serial output changes only on falling edges; driven while selected
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= !csn_s;
      if (sck_fall) begin
        sdo_reg <= tx_reg[7];
      end
    end
  end

  // conversion length by measurement and oversampling
  logic [CW-1:0] conv_len;
  logic [1:0]    oss_w;
  assign oss_w    = rx_byte[baro_pkg::OSS_MSB:baro_pkg::OSS_LSB];
  assign conv_len = !cmd_pres     ? CW'(CONV_TEMP_CYC) :
                    (oss_w == 2'h0) ? CW'(CONV_OSS0_CYC) :
                    (oss_w == 2'h1) ? CW'(CONV_OSS1_CYC) :
                    (oss_w == 2'h2) ? CW'(CONV_OSS2_CYC) :
                    CW'(CONV_OSS3_CYC);

  logic cmd_wr, conv_done;
  assign cmd_wr    = wr_stb && hit_cmd;
  assign conv_done = cmd_reg[baro_pkg::SCO_BIT] && (conv_cnt_reg == baro_pkg::CONV_ONE);

  // command register and conversion timer; restart beats a new command,
  // a new command beats completion so a restarted conversion is not cut short
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_reg      <= baro_pkg::CMD_RST;
      conv_cnt_reg <= baro_pkg::CONV_ZERO;
    end else if (srst_hit) begin
      cmd_reg      <= baro_pkg::CMD_RST;
      conv_cnt_reg <= baro_pkg::CONV_ZERO;
    end else if (cmd_wr) begin
      cmd_reg      <= {oss_w, cmd_valid, rx_byte[baro_pkg::MC_MSB:0]};
      conv_cnt_reg <= cmd_valid ? conv_len : baro_pkg::CONV_ZERO;
    end else if (conv_done) begin
      cmd_reg[baro_pkg::SCO_BIT] <= 1'b0;
      conv_cnt_reg               <= baro_pkg::CONV_ZERO;
    end else if (cmd_reg[baro_pkg::SCO_BIT]) begin
      conv_cnt_reg <= conv_cnt_reg - baro_pkg::CONV_ONE;
    end
  end

  // results change only when a conversion lands or on restart, so any read order is safe
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      res_hi_reg <= baro_pkg::RES_HI_RST;
      res_lo_reg <= baro_pkg::RES_LO_RST;
      res_xl_reg <= baro_pkg::RES_XL_RST;
    end else if (srst_hit) begin
      res_hi_reg <= baro_pkg::RES_HI_RST;
      res_lo_reg <= baro_pkg::RES_LO_RST;
      res_xl_reg <= baro_pkg::RES_XL_RST;
    end else if (conv_done && !cmd_wr) begin
      res_hi_reg <= adc_result_i[20:13];
      res_lo_reg <= adc_result_i[12:5];
      res_xl_reg <= {adc_result_i[baro_pkg::XL_BITS-1:0], baro_pkg::XL_PAD};
    end
  end

  assign sdo_o       = sdo_reg;
  assign sdo_oe_o    = sdo_oe_reg;
  assign conv_busy_o = cmd_reg[baro_pkg::SCO_BIT];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  sequence valid_cmd_s;
    cmd_wr && cmd_valid;
  endsequence

  sequence restart_s;
    srst_hit;
  endsequence

  busy_on_cmd_a: assert property (valid_cmd_s |=> conv_busy_o && res_hi_reg == $past(res_hi_reg))
    else $error("busy flag not raised or result lost on command");
  oss_eight_a: assert property (valid_cmd_s ##0 (cmd_pres && oss_w == 2'h3)
                                |=> conv_cnt_reg == CW'(CONV_OSS3_CYC))
    else $error("wrong conversion length for eight samples");
  done_result_a: assert property (conv_done && !cmd_wr && !srst_hit
                                  |=> !conv_busy_o && res_lo_reg == $past(adc_result_i[12:5]))
    else $error("result not stored when busy cleared");
  restart_clear_a: assert property (restart_s |=> cmd_reg == baro_pkg::CMD_RST
                                    && res_hi_reg == baro_pkg::RES_HI_RST && !conv_busy_o)
    else $error("restart did not clear registers");
  wrong_key_a: assert property (wr_stb && hit_srst && rx_byte != baro_pkg::SRST_KEY
                                |=> $stable(cmd_reg) || !$past(cmd_reg[baro_pkg::SCO_BIT]))
    else $error("restart taken with wrong key");
  results_hold_a: assert property (!conv_done && !srst_hit |=> $stable(res_hi_reg)
                                   && $stable(res_lo_reg) && $stable(res_xl_reg))
    else $error("results changed without conversion");
  part_code_a: assert property (load_pipe_reg[1] && ptr_reg == baro_pkg::ADDR_PART[AW-1:0]
                                |=> tx_reg == PART_CODE)
    else $error("part code not returned");
  addr_step_a: assert property (data_done && rd_mode_reg |=> ptr_reg == $past(ptr_reg) + 7'h01)
    else $error("read address did not advance");
  sdo_edge_a: assert property ($changed(sdo_o) |-> $past(sck_fall))
    else $error("serial output moved off a falling edge");
  ctrl_decode_a: assert property (ctrl_done |=> rd_mode_reg == $past(rx_reg[6]) && !ctrl_phase_reg)
    else $error("read flag not taken from first bit");

  // frame boundaries: a deselect drops partial bytes, oe tracks select
  frame_end_a: assert property (csn_s |=> bit_cnt_reg == 3'h0 && ctrl_phase_reg)
    else $error("frame state not cleared at deselect");
  oe_follow_a: assert property (1'b1 |=> sdo_oe_o == !$past(csn_s))
    else $error("output enable does not follow select");
  bit_wrap_a: assert property (byte_done |=> bit_cnt_reg == 3'h0)
    else $error("bit counter did not wrap after a byte");

  // conversion start, length and busy coupling to the timer
  bad_cmd_a: assert property (cmd_wr && !cmd_valid |=> !conv_busy_o)
    else $error("invalid command started a conversion");
  cmd_field_a: assert property (valid_cmd_s |=> cmd_reg[baro_pkg::MC_MSB:0]
                                == $past(rx_byte[baro_pkg::MC_MSB:0]))
    else $error("measurement code not stored");
  temp_len_a: assert property (valid_cmd_s ##0 !cmd_pres
                               |=> conv_cnt_reg == CW'(CONV_TEMP_CYC))
    else $error("wrong conversion length for temperature");
  timer_live_a: assert property (conv_busy_o |-> conv_cnt_reg != baro_pkg::CONV_ZERO)
    else $error("busy flag set with idle timer");
  xl_pad_a: assert property (res_xl_reg[2:0] == baro_pkg::XL_PAD)
    else $error("extra result padding bits not zero");

endmodule : baro_sensor_spi_regmap

`default_nettype wire

// >>> test/baro_spi_master.sv
`timescale 1ns/1ps
`default_nettype none

// far-side master of the serial link: mode 3, msb first, 80 ns link clock
module baro_spi_master #(
  parameter int START_NS = 500
) (
  output var  logic sck_o,
  output var  logic csn_o,
  output var  logic sdi_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  logic ready;

  // start-up wait shortened from 10 ms to keep the run short
  initial begin
    sck_o = 1'b1;
    csn_o = 1'b1;
    sdi_o = 1'b0;
    ready = 1'b0;
    #(START_NS) ready = 1'b1;
  end

  // one frame of n bytes; tx left aligned, rx collects sdo, x while not driven
  task automatic frame(input logic [47:0] tx, input int n, output logic [47:0] rx);
    wait (ready);
    rx = '0;
    csn_o = 1'b0;
    #40;
    for (int i = 0; i < n * 8; i++) begin
      sck_o = 1'b0;
      sdi_o = tx[47-i];
      #40;
      sck_o = 1'b1;
      rx = {rx[46:0], (sdo_oe_i === 1'b1) ? sdo_i : 1'bx};
      #40;
    end
    csn_o = 1'b1;
    sdi_o = ~sdi_o; // released line must not look like stale data
    #80;
  endtask : frame
endmodule : baro_spi_master

`default_nettype wire

// >>> test/baro_sensor_spi_regmap_tb.sv
`timescale 1ns/1ps
`default_nettype none

module baro_sensor_spi_regmap_tb;
  localparam int CT = 1000;
  localparam int C0 = 1100;
  localparam int C1 = 1300;
  localparam int C2 = 1500;
  localparam int C3 = 1800;
  localparam logic [31:0] CAL_HEAD = 32'h1A2B3C4D;
  localparam logic [7:0] CAL_TAIL = 8'h6F;

  logic        mclk_i = 1'b0;
  logic        resetn_i;
  logic        sck;
  logic        csn;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic        busy;
  logic [20:0] adc_result_i;
  logic [31:0] seed;
  logic [47:0] rx;
  logic [23:0] exp_res;
  logic [7:0]  cmds [5] = '{8'h2E, 8'h34, 8'h74, 8'hB4, 8'hF4};
  int          cycs [5] = '{CT, C0, C1, C2, C3};
  int          err_count = 0;
  int          check_count = 0;
  time         t0;

  always #2.5 mclk_i = ~mclk_i;

  baro_sensor_spi_regmap #(
    .CONV_TEMP_CYC(CT), .CONV_OSS0_CYC(C0), .CONV_OSS1_CYC(C1),
    .CONV_OSS2_CYC(C2), .CONV_OSS3_CYC(C3)
  ) i_dut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .sck_i(sck), .csn_i(csn), .sdi_i(sdi),
    .adc_result_i(adc_result_i), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .conv_busy_o(busy)
  );

  baro_spi_master i_master (
    .sck_o(sck), .csn_o(csn), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe)
  );

  // repeatable pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_range(input string name, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask : chk_range

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    i_master.frame({1'b0, a[6:0], d, 32'h0}, 2, rx);
  endtask : wr

  task automatic rd(input logic [7:0] a, input int n);
    @(negedge mclk_i);
    i_master.frame({1'b1, a[6:0], 40'h0}, n + 1, rx);
  endtask : rd

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // hang guard, well beyond the expected run length
  initial begin
    repeat (60000) @(posedge mclk_i);
    err_count++;
    complete_run();
  end

  // main sequence
  initial begin
    resetn_i = 1'b0;
    adc_result_i = '0;
    seed = 32'hA891;
    exp_res = 24'h800000;
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i) resetn_i = 1'b1;
    @(negedge mclk_i);
    chk("busy", 0, busy);
    chk("oe", 0, sdo_oe);
    rd(baro_pkg::ADDR_CMD, 1);
    chk("cmd", 0, rx[7:0]);
    rd(baro_pkg::ADDR_RES_HI, 3);
    chk("res", exp_res, rx[23:0]);
    rd(baro_pkg::ADDR_PART, 1);
    chk("part", baro_pkg::PART_CODE_DEF, rx[7:0]);
    rd(baro_pkg::ADDR_SRST, 1);
    chk("restart_rd", 0, rx[7:0]);
    // only mapped addresses are touched; reserved ones stay alone
    rd(baro_pkg::ADDR_RES_XL, 1);
    chk("xl_rst", 0, rx[7:0]);
    rd(baro_pkg::ADDR_CAL_FIRST, 4);
    chk("cal_head", CAL_HEAD, rx[31:0]);
    rd(baro_pkg::ADDR_CAL_LAST, 1);
    chk("cal_tail", CAL_TAIL, rx[7:0]);
    // every command code and oversampling setting
    for (int k = 0; k < 5; k++) begin
      seed = lfsr(seed);
      @(negedge mclk_i) adc_result_i = seed[20:0];
      wr(baro_pkg::ADDR_CMD, cmds[k]);
      t0 = $time;
      chk("busy_set", 1, busy);
      rd(baro_pkg::ADDR_CMD, 1);
      chk("cmd_run", cmds[k], rx[7:0]);
      rd(baro_pkg::ADDR_RES_HI, 3);
      chk("res_old", exp_res, rx[23:0]);
      while (busy === 1'b1 && ($time - t0) < 20000) @(negedge mclk_i);
      chk_range("conv_cyc", cycs[k] - 30, cycs[k] - 10, int'(($time - t0) / 5));
      exp_res = {adc_result_i, 3'h0};
      rd(baro_pkg::ADDR_CMD, 1);
      chk("cmd_done", cmds[k] & 8'hDF, rx[7:0]);
      for (int j = 2; j >= 0; j--) begin
        rd(baro_pkg::ADDR_RES_HI + 8'(j), 1);
        chk("res_one", exp_res[23-8*j -: 8], rx[7:0]);
      end
      rd(baro_pkg::ADDR_RES_HI, 3);
      chk("res_burst", exp_res, rx[23:0]);
    end
    // invalid code is stored without busy; read-only places ignore writes
    seed = lfsr(seed);
    wr(baro_pkg::ADDR_CMD, 8'h35);
    chk("busy_bad", 0, busy);
    rd(baro_pkg::ADDR_CMD, 1);
    chk("cmd_bad", 8'h15, rx[7:0]);
    wr(baro_pkg::ADDR_RES_HI, seed[7:0] ^ exp_res[23:16] ^ 8'hFF);
    wr(baro_pkg::ADDR_PART, seed[15:8] ^ baro_pkg::PART_CODE_DEF ^ 8'hFF);
    rd(baro_pkg::ADDR_RES_HI, 1);
    chk("ro_res", exp_res[23:16], rx[7:0]);
    rd(baro_pkg::ADDR_PART, 1);
    chk("ro_part", baro_pkg::PART_CODE_DEF, rx[7:0]);
    // restart: wrong key ignored, key aborts conversion and clears results
    wr(baro_pkg::ADDR_CMD, 8'h2E);
    wr(baro_pkg::ADDR_SRST, 8'hB7);
    chk("busy_key", 1, busy);
    wr(baro_pkg::ADDR_SRST, baro_pkg::SRST_KEY);
    chk("busy_abort", 0, busy);
    rd(baro_pkg::ADDR_CMD, 1);
    chk("cmd_clr", 0, rx[7:0]);
    rd(baro_pkg::ADDR_RES_HI, 3);
    chk("res_clr", 24'h800000, rx[23:0]);
    repeat (CT) @(negedge mclk_i);
    chk("busy_stay", 0, busy);
    // reset in mid-run returns the command register to its reset value
    wr(baro_pkg::ADDR_CMD, 8'hF4);
    @(negedge mclk_i) resetn_i = 1'b0;
    repeat (4) @(negedge mclk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk("busy_rst", 0, busy);
    rd(baro_pkg::ADDR_CMD, 1);
    chk("cmd_rst", 0, rx[7:0]);
    complete_run();
  end
endmodule : baro_sensor_spi_regmap_tb

`default_nettype wire
